// ==== rtl/jump_incr_exec.sv ====
// Executor for the absolute jump and increment-file instructions
`timescale 1ns/1ps
module jump_incr_exec
(
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   // Program memory word fetch
   input  wire logic [15:0]                prog_word,
   output      logic [20:0]                program_counter,
   // Data memory
   output      jump_incr_pkg::dmem_req_s   dmem_req,
   input  wire logic [7:0]                 dmem_rdata,
   // Core context
   input  wire logic                       ext_set_en,
   input  wire logic [3:0]                 bank_select_register,
   input  wire logic [11:0]                index_base,
   // Architectural state out
   output      logic [7:0]                 working_reg,
   output      logic [4:0]                 status_flags,
   output      logic                       busy_second_cycle
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed
   {
      jump_incr_pkg::phase_e     phase;     // Current Q phase
      logic [15:0]               ir;        // Latched instruction word
      logic                      nop_cycle; // Idle second jump cycle
      logic [7:0]                k_low;     // Low target byte
      logic [7:0]                data;      // Fetched file byte
      logic [20:0]               counter;   // Byte program counter, bit 0 zero
      logic [7:0]                wreg;      // Working register
      logic [4:0]                status;    // Sign, overflow, zero, digit carry, carry
      jump_incr_pkg::dmem_req_s  req;       // Data memory strobes and address
   } state_s;

   // One registered word and the copy that the decode fills
   state_s                   st_reg;     // Registered state
   state_s                   st_next;    // Next state
   logic [1:0]               rst_sync;   // Reset release synchroniser
   logic                     rst_n_int;  // Released reset
   jump_incr_pkg::incr_res_s alu_res;    // Incremented byte and flags
   logic                     is_jump;    // Decoded first jump word
   logic                     is_incr;    // Decoded increment word
   logic [11:0]              file_addr;  // Resolved data address

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   // Clears at once on the pin, sets one stage per edge
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   // Assertion is immediate; release waits two edges so no state flop
   // sees reset drop close to a clock edge
   assign rst_n_int = rst_sync[1];

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   // Type decode uses only the latched word; after Q1 the fetch bus is read again only for a jump's second word at Q4;
   // an unknown word decodes as neither and just advances the counter
   assign is_jump = (st_reg.ir[15:8] == jump_incr_pkg::JUMP_OP_HI);
   assign is_incr = (st_reg.ir[15:10] == jump_incr_pkg::INCR_OP);

   // ------------------------------------------------------------
   // Address resolution for the increment operand
   // ------------------------------------------------------------
   // Pure decode of the latched word; the bank inputs are read live, so
   // the core must hold them steady through Q2
   always_comb
   begin
      // Access bit clear: indexed window first, then the access bank
      if (!st_reg.ir[jump_incr_pkg::ACC_BIT])
      begin
         if (ext_set_en && st_reg.ir[7:0] <= jump_incr_pkg::INDEX_LIMIT)
            file_addr = index_base + {4'h0, st_reg.ir[7:0]};
         else if (st_reg.ir[7:0] < jump_incr_pkg::ACCESS_SPLIT)
            file_addr = {4'h0, st_reg.ir[7:0]};
         else
            file_addr = {jump_incr_pkg::ACCESS_HI_BANK, st_reg.ir[7:0]};
      end
      else
         file_addr = {bank_select_register, st_reg.ir[7:0]};
   end

   // ------------------------------------------------------------
   // Incrementer
   // ------------------------------------------------------------
   // Fed from the captured byte, not the bus, so sum and flags have a
   // whole clock to settle before the Q4 edge uses them
   incr_alu u_alu
   (
      .operand (st_reg.data),
      .result  (alu_res)
   );

   // ------------------------------------------------------------
   // Phase sequencer and execution
   // ------------------------------------------------------------
   always_comb
   begin
      // Hold everything by default; strobes are one-cycle pulses
      st_next = st_reg;
      st_next.req.rd = 1'b0;
      st_next.req.wr = 1'b0;
      case (st_reg.phase)
         jump_incr_pkg::PH_Q1:
         begin
            // Decode: latch the fetched word unless in the idle second jump cycle
            st_next.phase = jump_incr_pkg::PH_Q2;
            if (!st_reg.nop_cycle)
               st_next.ir = prog_word;
         end
         jump_incr_pkg::PH_Q2:
         begin
            // Read phase: low target byte or file byte
            st_next.phase = jump_incr_pkg::PH_Q3;
            if (st_reg.nop_cycle)
               st_next.nop_cycle = st_reg.nop_cycle;
            else if (is_jump)
               st_next.k_low = st_reg.ir[7:0];
            else if (is_incr)
            begin
               st_next.req.rd   = 1'b1;
               st_next.req.addr = file_addr;
            end
         end
         jump_incr_pkg::PH_Q3:
         begin
            // Process phase: capture the byte while the read strobe stands
            st_next.phase = jump_incr_pkg::PH_Q4;
            if (!st_reg.nop_cycle && is_incr)
               st_next.data = dmem_rdata;
         end
         jump_incr_pkg::PH_Q4:
         begin
            // Write phase: counter, then flags and destination
            st_next.phase = jump_incr_pkg::PH_Q1;
            if (st_reg.nop_cycle)
               st_next.nop_cycle = 1'b0;
            else if (is_jump)
            begin
               // Second word is presented at the next fetch address;
               // a word without the prefix is refused and only steps on
               if (prog_word[15:12] == jump_incr_pkg::JUMP_OP_SEC)
               begin
                  st_next.counter = {prog_word[11:0], st_reg.k_low, 1'b0};
                  st_next.nop_cycle = 1'b1;
               end
               else
                  st_next.counter = st_reg.counter + 21'h000002;
            end
            else
            begin
               st_next.counter = st_reg.counter + 21'h000002;
               if (is_incr)
               begin
                  st_next.status = alu_res.flags;
                  if (st_reg.ir[jump_incr_pkg::DEST_BIT])
                  begin
                     st_next.req.wr    = 1'b1;
                     st_next.req.wdata = alu_res.sum;
                  end
                  else
                     st_next.wreg = alu_res.sum;
               end
            end
         end
         default:
            st_next.phase = jump_incr_pkg::PH_Q1;
      endcase
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   // Only constants in the reset branch; everything else arrives
   // through the next-state copy
   always_ff @(posedge clk or negedge rst_n_int)
   begin
      if (!rst_n_int)
      begin
         st_reg.phase     <= jump_incr_pkg::PH_Q1;
         st_reg.ir        <= 16'h0000;
         st_reg.nop_cycle <= 1'b0;
         st_reg.k_low     <= 8'h00;
         st_reg.data      <= 8'h00;
         st_reg.counter   <= jump_incr_pkg::COUNTER_RST;
         st_reg.wreg      <= jump_incr_pkg::WREG_RST;
         st_reg.status    <= jump_incr_pkg::STATUS_RST;
         st_reg.req       <= '0;
      end
      else
         st_reg <= st_next;
   end

   // ------------------------------------------------------------
   // Outputs straight from flip-flops
   // ------------------------------------------------------------
   // Busy lets the fetch side see that the fetched word is being skipped
   assign program_counter   = st_reg.counter;
   assign dmem_req          = st_reg.req;
   assign working_reg       = st_reg.wreg;
   assign status_flags      = st_reg.status;
   assign busy_second_cycle = st_reg.nop_cycle;
endmodule : jump_incr_exec

// ==== rtl/jump_incr_pkg.sv ====
// Package: shared constants and carriers for the jump / increment executor
package jump_incr_pkg;
   // ------------------------------------------------------------
   // Opcode fields
   // ------------------------------------------------------------
   localparam logic [7:0]  JUMP_OP_HI   = 8'hEF;  // First jump word, bits 15:8
   localparam logic [3:0]  JUMP_OP_SEC  = 4'hF;   // Second jump word, bits 15:12
   localparam logic [5:0]  INCR_OP      = 6'h0A;  // Increment word, bits 15:10
   localparam int          DEST_BIT     = 9;      // Destination select position
   localparam int          ACC_BIT      = 8;      // Access select position
   localparam logic [7:0]  INDEX_LIMIT  = 8'h5F;  // Indexed window top
   localparam logic [3:0]  ACCESS_HI_BANK = 4'hF; // Access bank upper half
   localparam logic [7:0]  ACCESS_SPLIT = 8'h60;  // Access bank split point
   // ------------------------------------------------------------
   // Status bit positions
   // ------------------------------------------------------------
   localparam int ST_C     = 0;  // Carry
   localparam int ST_DIGIT = 1;  // Digit carry
   localparam int ST_Z     = 2;  // Zero
   localparam int ST_OVFL  = 3;  // Signed overflow
   localparam int ST_N     = 4;  // Negative
   localparam logic [4:0] STATUS_RST = 5'h00;
   localparam logic [20:0] COUNTER_RST = 21'h000000;
   localparam logic [7:0]  WREG_RST  = 8'h00;
   localparam logic [3:0]  BANK_RST  = 4'h0;
   localparam logic [11:0] FSR2_RST  = 12'h000;

   // Instruction cycle phases, one-hot
   typedef enum logic [3:0]
   {
      PH_Q1 = 4'h1,
      PH_Q2 = 4'h2,
      PH_Q3 = 4'h4,
      PH_Q4 = 4'h8
   } phase_e;

   // Data memory request carrier
   typedef struct packed
   {
      logic        rd;    // Read strobe
      logic        wr;    // Write strobe
      logic [11:0] addr;  // Full data address
      logic [7:0]  wdata; // Write data
   } dmem_req_s;

   // Increment result carrier
   typedef struct packed
   {
      logic [7:0] sum;
      logic [4:0] flags;
   } incr_res_s;
endpackage : jump_incr_pkg

// ==== rtl/incr_alu.sv ====
// Incrementer with status flag generation
`timescale 1ns/1ps
module incr_alu
(
   // Operand
   input  wire logic [7:0]                 operand,
   // Result and flags
   output      jump_incr_pkg::incr_res_s   result
);
   // ------------------------------------------------------------
   // Add one and derive flags
   // ------------------------------------------------------------
   logic [8:0] wide;  // Carry out in bit 8
   logic [4:0] low;   // Carry out of bit 3 in bit 4

   always_comb
   begin
      wide = {1'b0, operand} + 9'h001;
      low  = {1'b0, operand[3:0]} + 5'h01;
      result.sum = wide[7:0];
      result.flags = '0;
      result.flags[jump_incr_pkg::ST_C]  = wide[8];
      result.flags[jump_incr_pkg::ST_DIGIT] = low[4];
      result.flags[jump_incr_pkg::ST_Z]  = (wide[7:0] == 8'h00);
      // Signed overflow only when 7Fh rolls to 80h
      result.flags[jump_incr_pkg::ST_OVFL] = ~operand[7] & wide[7];
      result.flags[jump_incr_pkg::ST_N]  = wide[7];
   end
endmodule : incr_alu

// ==== sim/data_mem_model.sv ====
// Behavioural data memory facing the executor
`timescale 1ns/1ps
module data_mem_model
(
   // Clock
   input  wire logic                     clk,
   // Request and read data
   input  wire jump_incr_pkg::dmem_req_s dmem_req,
   output      logic [7:0]               dmem_rdata
);
   logic [7:0] cells [4096]; // Whole data space
   logic [7:0] last_q;       // Last byte handed out
   initial
   begin
      foreach (cells[i]) cells[i] = 8'h33;
      last_q = 8'h00;
   end
   // Unselected bus shows flipped data, so a stale byte never passes
   assign dmem_rdata = dmem_req.rd ? cells[dmem_req.addr] : ~last_q;
   always @(posedge clk)
   begin
      if (dmem_req.rd) last_q <= cells[dmem_req.addr];
      if (dmem_req.wr) cells[dmem_req.addr] <= dmem_req.wdata;
   end
endmodule : data_mem_model

// ==== sim/jump_incr_exec_monitor.sv ====
// Port checks for the jump / increment executor
`timescale 1ns/1ps
module jump_incr_exec_monitor
(
   // Clock, reset and watched ports
   input wire logic                     clk,
   input wire logic                     reset_n,
   input wire logic [15:0]              prog_word,
   input wire logic [20:0]              program_counter,
   input wire jump_incr_pkg::dmem_req_s dmem_req,
   input wire logic [7:0]               dmem_rdata,
   input wire logic                     ext_set_en,
   input wire logic [3:0]               bank_select_register,
   input wire logic [11:0]              index_base,
   input wire logic [7:0]               working_reg,
   input wire logic [4:0]               status_flags,
   input wire logic                     busy_second_cycle
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Read strobe, then the outcome two edges later
   sequence s_read;
      dmem_req.rd;
   endsequence
   sequence s_result;
      ##2 (dmem_req.wr ? dmem_req.wdata == 8'($past(dmem_rdata, 2) + 8'h01)
                       : working_reg == 8'($past(dmem_rdata, 2) + 8'h01));
   endsequence
   AST_INCR_RESULT: assert property (s_read |-> s_result)
      else $error("increment result wrong");
   AST_DEST_SELECT: assert property (s_read |-> ##2 dmem_req.wr == $past(prog_word[9], 4))
      else $error("destination select wrong");
   AST_BANKED_ADDR: assert property (dmem_req.rd && $past(prog_word[8], 2) |->
      dmem_req.addr == {bank_select_register, $past(prog_word[7:0], 2)})
      else $error("banked address wrong");
   AST_ACCESS_ADDR: assert property (dmem_req.rd && !$past(prog_word[8], 2) &&
      !(ext_set_en && $past(prog_word[7:0], 2) <= 8'h5F) |-> dmem_req.addr ==
      {($past(prog_word[7:0], 2) < 8'h60) ? 4'h0 : 4'hF, $past(prog_word[7:0], 2)})
      else $error("access bank address wrong");
   AST_INDEX_ADDR: assert property (dmem_req.rd && !$past(prog_word[8], 2) && ext_set_en &&
      $past(prog_word[7:0], 2) <= 8'h5F |-> dmem_req.addr == index_base + $past(prog_word[7:0], 2))
      else $error("indexed address wrong");
   AST_INCR_FLAGS: assert property (s_read |-> ##2 (
      status_flags[jump_incr_pkg::ST_Z] == ($past(dmem_rdata, 2) == 8'hFF) &&
      status_flags[jump_incr_pkg::ST_C] == ($past(dmem_rdata, 2) == 8'hFF) &&
      status_flags[jump_incr_pkg::ST_DIGIT] == ($past(dmem_rdata[3:0], 2) == 4'hF)))
      else $error("increment flags wrong");
   AST_ONE_READ: assert property (s_read |=> !dmem_req.rd ##1 !dmem_req.rd)
      else $error("read strobe too long");
   AST_JUMP_TARGET: assert property ($rose(busy_second_cycle) |->
      $past(prog_word[15:12], 1) == 4'hF && status_flags == $past(status_flags, 4) &&
      program_counter == {$past(prog_word[11:0], 1), $past(prog_word[7:0], 4), 1'b0})
      else $error("jump target wrong");
   AST_IDLE_SECOND: assert property ($rose(busy_second_cycle) |->
      (busy_second_cycle && !dmem_req.rd && !dmem_req.wr)[*4] ##1 !busy_second_cycle)
      else $error("second jump cycle not idle");
   AST_PC_EVEN: assert property (program_counter[0] == 1'b0)
      else $error("counter bit 0 set");
endmodule : jump_incr_exec_monitor
bind jump_incr_exec jump_incr_exec_monitor mon (.clk, .reset_n, .prog_word, .program_counter,
   .dmem_req, .dmem_rdata, .ext_set_en, .bank_select_register, .index_base, .working_reg,
   .status_flags, .busy_second_cycle);

// ==== sim/cpu_jump_and_increment_exec_bench.sv ====
// Self-checking bench for the jump / increment executor
`timescale 1ns/1ps
module cpu_jump_and_increment_exec_bench;
   logic                     clk, reset_n, ext_set_en, busy_second_cycle;
   logic [15:0]              prog_word;
   logic [3:0]               bank_select_register;
   logic [11:0]              index_base;
   logic [7:0]               dmem_rdata, working_reg;
   logic [20:0]              program_counter;
   logic [4:0]               status_flags;
   jump_incr_pkg::dmem_req_s dmem_req;
   int                       err_count, total_checks;
   jump_incr_exec dut (.clk, .reset_n, .prog_word, .program_counter, .dmem_req, .dmem_rdata,
      .ext_set_en, .bank_select_register, .index_base, .working_reg, .status_flags,
      .busy_second_cycle);
   data_mem_model mem (.clk, .dmem_req, .dmem_rdata);
   always #10 clk = ~clk;
   // ------------------------------------------------------------
   // Checking
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   // Next slot's first edge passes; earlier results still stand here
   task automatic peek(input logic [15:0] w);
      prog_word <= w;
      @(posedge clk);
      @(negedge clk);
   endtask : peek
   task automatic incr_case(input logic [11:0] a, input logic [7:0] f, input logic [1:0] da,
                            input logic ext, input logic [7:0] v, input logic [4:0] flg);
      logic [7:0] w;
      w = working_reg;
      mem.cells[a] = v;
      ext_set_en <= ext;
      prog_word <= {jump_incr_pkg::INCR_OP, da, f};
      repeat (4) @(posedge clk);
      peek(16'h0000);
      check(da[1] ? mem.cells[a] : working_reg, 8'(v + 8'h01));
      check(da[1] ? working_reg : mem.cells[a], da[1] ? w : v);
      check(status_flags, flg);
      repeat (3) @(posedge clk);
   endtask : incr_case
   // Idle cycle carries an increment word that must be ignored
   task automatic jump_case(input logic [19:0] k, input logic [3:0] pre);
      logic [20:0] ctr;
      logic [4:0]  st;
      logic [7:0]  c;
      c = mem.cells[12'h310];
      prog_word <= {jump_incr_pkg::JUMP_OP_HI, k[7:0]};
      @(posedge clk);
      prog_word <= {pre, k[19:8]};
      @(negedge clk);
      ctr = program_counter;
      st = status_flags;
      repeat (3) @(posedge clk);
      peek({jump_incr_pkg::INCR_OP, 2'b11, 8'h10});
      check(program_counter, pre == 4'hF ? {k, 1'b0} : ctr + 21'h2);
      check(status_flags, st);
      check(busy_second_cycle, pre == 4'hF);
      repeat (3) @(posedge clk);
      // A refused jump runs the increment; its write lands one edge on
      peek(16'h0000);
      check(mem.cells[12'h310], pre == 4'hF ? c : 8'(c + 8'h01));
      // Finish the filler slot so the next scenario starts on a Q4 edge
      repeat (3) @(posedge clk);
   endtask : jump_case
   // ------------------------------------------------------------
   // Verdict
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   // Watchdog: the scenarios need about 120 cycles, 5000 only trips on a hang
   initial
   begin
      #100000;
      err_count++;
      stop_test();
   end
   initial
   begin
      clk = 1'b0;
      reset_n = 1'b0;
      prog_word = 16'h0000;
      ext_set_en = 1'b0;
      bank_select_register = 4'h3;
      index_base = 12'h200;
      err_count = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      // Increments first: the first leaves cell 310h at 00h; the jump scenarios read its value at their start
      incr_case(12'h310, 8'h10, 2'b11, 1'b0, 8'hFF, 5'h07);
      incr_case(12'h020, 8'h20, 2'b00, 1'b0, 8'h7F, 5'h1A);
      incr_case(12'hFA0, 8'hA0, 2'b10, 1'b0, 8'h0F, 5'h02);
      incr_case(12'h25F, 8'h5F, 2'b10, 1'b1, 8'h41, 5'h00);
      incr_case(12'hF60, 8'h60, 2'b10, 1'b1, 8'h05, 5'h00);
      incr_case(12'h200, 8'h00, 2'b00, 1'b1, 8'h8F, 5'h12);
      incr_case(12'h3FF, 8'hFF, 2'b01, 1'b0, 8'h00, 5'h00);
      jump_case(20'hFFFFF, 4'hF);
      jump_case(20'h00000, 4'hF);
      jump_case(20'h12345, 4'hF);
      jump_case(20'hABCDE, 4'hE);
      stop_test();
   end
endmodule : cpu_jump_and_increment_exec_bench
